//--- csc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module csc_core_model
  import csc_pkg::*;
(
  input  wire logic       i_clk,
  output csc_alu_s        o_alu,
  output logic      [1:0] o_ovf,
  output logic      [1:0] o_sat,
  output logic            o_do,
  output logic            o_rep,
  output logic      [2:0] o_depth,
  output logic            o_fset,
  output logic            o_fclr,
  output logic            o_iload,
  output logic      [3:0] o_ipl,
  output logic            o_nest
);
  initial {o_alu, o_ovf, o_sat, o_do, o_rep, o_depth, o_fset, o_fclr,
           o_iload, o_ipl, o_nest} = '0;

  task automatic step;
    @(posedge i_clk);
    #1;
  endtask : step

  // Borrow is handed over already inverted as carry_msb
  task automatic alu(input csc_alu_s a);
    step();
    o_alu = a;
    step();
    o_alu = '0;
  endtask : alu

  // One-cycle pulses; the flags have landed when this returns
  task automatic pulse(input logic [1:0] s, f, input logic [4:0] l);
    step();
    {o_sat, o_fset, o_fclr, o_iload, o_ipl} = {s, f, l};
    step();
    {o_sat, o_fset, o_fclr, o_iload} = '0;
  endtask : pulse

  task automatic lvl(input logic [1:0] v, input logic d, r,
                     input logic [2:0] n, input logic ns);
    step();
    {o_ovf, o_do, o_rep, o_depth, o_nest} = {v, d, r, n, ns};
    step();
  endtask : lvl
endmodule : csc_core_model
`default_nettype wire

//--- csc_pkg.sv
package csc_pkg;

  // -------------------------------------------------------------------------
  // Status register field positions
  // -------------------------------------------------------------------------
  localparam int unsigned ST_AOVF    = 15;
  localparam int unsigned ST_BOVF    = 14;
  localparam int unsigned ST_ASAT    = 13;
  localparam int unsigned ST_BSAT    = 12;
  localparam int unsigned ST_OVF_ANY = 11;
  localparam int unsigned ST_SAT_ANY = 10;
  localparam int unsigned ST_DO      = 9;
  localparam int unsigned ST_HALF    = 8;
  localparam int unsigned ST_PRIH    = 7;
  localparam int unsigned ST_PRIL    = 5;
  localparam int unsigned ST_REP     = 4;
  localparam int unsigned ST_NEG     = 3;
  localparam int unsigned ST_SOVF    = 2;
  localparam int unsigned ST_ZERO    = 1;
  localparam int unsigned ST_CARRY   = 0;

  // -------------------------------------------------------------------------
  // Core control register field positions
  // -------------------------------------------------------------------------
  localparam int unsigned CC_VAR    = 15;
  localparam int unsigned CC_USH    = 13;
  localparam int unsigned CC_USL    = 12;
  localparam int unsigned CC_ETERM   = 11;
  localparam int unsigned CC_DLH     = 10;
  localparam int unsigned CC_DLL     = 8;
  localparam int unsigned CC_ASATEN  = 7;
  localparam int unsigned CC_BSATEN  = 6;
  localparam int unsigned CC_DWSATEN = 5;
  localparam int unsigned CC_SATMODE = 4;
  localparam int unsigned CC_PRITOP  = 3;
  localparam int unsigned CC_FRAME   = 2;
  localparam int unsigned CC_ROUND   = 1;
  localparam int unsigned CC_IF     = 0;

  // -------------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------------
  localparam logic [15:0] ST_RESET  = 16'h0000;
  localparam logic [15:0] CC_RESET  = 16'h0020;
  localparam logic [2:0]  IPL_LOCK  = 3'h7;

  typedef enum logic [1:0] {
    CSC_MUL_SIGNED,
    CSC_MUL_UNSIGNED,
    CSC_MUL_MIXED,
    CSC_MUL_RSVD
  } csc_mul_e;

  // One ALU result as reported by the execution core
  typedef struct packed {
    logic upd_c;
    logic upd_z;
    logic upd_n;
    logic upd_ov;
    logic upd_dc;
    logic byte_op;
    logic subtract;
    logic carry_msb;
    logic carry_b4;
    logic carry_b8;
    logic neg;
    logic zero;
    logic z_keep;
    logic ovf;
  } csc_alu_s;

  // DSP engine settings
  typedef struct packed {
    csc_mul_e mul_type;
    logic     mul_integer;
    logic     round_biased;
    logic     acc_a_sat_enable;
    logic     acc_b_sat_enable;
    logic     data_write_sat_enable;
    logic     super_sat;
  } csc_dsp_s;

endpackage : csc_pkg

//--- csc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Per-accumulator overflow flags follow the core's current overflow levels.
// - Saturation events set per-accumulator sticky flags held until software clears.
// - Combined overflow flag is the OR of both accumulator overflow flags.
// - Combined sticky flag is the OR of both sticky saturation flags.
// - Status writes clear sticky flags directly or by writing zero to combined bit.
// - DO loop active flag mirrors the core's loop state.
// - Half carry takes bit-4 carry for bytes, bit-8 carry for words.
// - Priority level is core-control top bit above three status bits.
// - User interrupts off when low bits are 111 or top bit set.
// - Low priority bits ignore software writes while nesting is disabled.
// - REPEAT loop active flag mirrors the core's repeat state.
// - Negative flag follows the sign of the ALU result.
// - Overflow flag follows the signed overflow of the operation.
// - Zero flag clears on non-zero result, may be held on zero result.
// - Carry flag takes the carry out of the result MSB.
// - Writing one to early terminate ends the DO loop; reads zero.
// - Loop nesting depth is a read-only three-bit field.
// - Saturation mode bit selects super saturation or normal saturation.
// - Active stack frame maps frame and stack pointer to flat 64K.
// - Rounding select picks biased rounding; mode select picks integer multiply.
// - Carry and half carry act as borrow flags on subtraction.
module csc_regs
  import csc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Memory-mapped instruction access
  input  wire logic        i_sr_wr,
  input  wire logic        i_cc_wr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_sr_rdata,
  output logic      [15:0] o_cc_rdata,
  // Execution core
  input  wire csc_alu_s    i_alu,
  input  wire logic        i_acc_a_ovf,
  input  wire logic        i_acc_b_ovf,
  input  wire logic        i_acc_a_sat,
  input  wire logic        i_acc_b_sat,
  input  wire logic        i_do_active,
  input  wire logic        i_repeat_active,
  input  wire logic [2:0]  i_do_depth,
  input  wire logic        i_frame_set,
  input  wire logic        i_frame_clr,
  // Interrupt priority logic
  input  wire logic        i_ipl_load,
  input  wire logic [3:0]  i_ipl_value,
  input  wire logic        i_nest_disable,
  // Outputs to core and interrupt logic
  output logic      [3:0]  o_cpu_ipl,
  output logic             o_user_irq_disable,
  output logic             o_early_terminate,
  output logic             o_stack_frame_flat,
  output logic             o_var_exception,
  output csc_dsp_s         o_dsp_cfg
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  logic       acc_a_overflow_q;
  logic       acc_b_overflow_q;
  logic       acc_a_sticky_sat_q, acc_a_sticky_sat_d;
  logic       acc_b_sticky_sat_q, acc_b_sticky_sat_d;
  logic       do_loop_active_q;
  logic       repeat_loop_active_q;
  logic       half_carry_flag_q, half_carry_flag_d;
  logic [2:0] priority_low_bits_q, priority_low_bits_d;
  logic       priority_top_bit_q, priority_top_bit_d;
  logic       negative_q, negative_d;
  logic       signed_overflow_flag_q, signed_overflow_flag_d;
  logic       zero_q, zero_d;
  logic       carry_q, carry_d;
  logic       var_q;
  logic [1:0] multiply_sign_select_q;
  logic [2:0] loop_nest_depth_q;
  logic       early_loop_terminate_q;
  logic       acc_a_sat_enable_q;
  logic       acc_b_sat_enable_q;
  logic       data_write_sat_enable_q;
  logic       sat_mode_select_q;
  logic       stack_frame_active_q, stack_frame_active_d;
  logic       rounding_select_q;
  logic       int_mode_q;

  // -------------------------------------------------------------------------
  // Derived flags
  // -------------------------------------------------------------------------
  wire logic combined_overflow   = acc_a_overflow_q | acc_b_overflow_q;
  wire logic combined_sticky_sat =
    acc_a_sticky_sat_q | acc_b_sticky_sat_q;

  // Software may only clear; writing zero to the combined bit clears both
  wire logic sw_keep_a = i_wdata[ST_ASAT] & i_wdata[ST_SAT_ANY];
  wire logic sw_keep_b = i_wdata[ST_BSAT] & i_wdata[ST_SAT_ANY];

  // Hardware saturation wins over a clearing write in the same cycle
  assign acc_a_sticky_sat_d = i_acc_a_sat |
    (acc_a_sticky_sat_q & ~(i_sr_wr & ~sw_keep_a));
  assign acc_b_sticky_sat_d = i_acc_b_sat |
    (acc_b_sticky_sat_q & ~(i_sr_wr & ~sw_keep_b));

  // -------------------------------------------------------------------------
  // ALU flags: a result in the same cycle as a write takes precedence
  // -------------------------------------------------------------------------
  // The core reports the raw adder carry; on subtraction it is already the
  // inverted borrow, so both carries pass through unchanged.
  wire logic alu_dc =
    i_alu.byte_op ? i_alu.carry_b4 : i_alu.carry_b8;
  wire logic alu_c  = i_alu.carry_msb;
  wire logic alu_z  = i_alu.zero ? (i_alu.z_keep ? zero_q : 1'b1)
                                 : 1'b0;

  assign carry_d = i_alu.upd_c ? alu_c :
                   i_sr_wr ? i_wdata[ST_CARRY] : carry_q;
  assign zero_d = i_alu.upd_z ? alu_z :
                  i_sr_wr ? i_wdata[ST_ZERO] : zero_q;
  assign negative_d = i_alu.upd_n ? i_alu.neg :
                      i_sr_wr ? i_wdata[ST_NEG] : negative_q;
  assign signed_overflow_flag_d = i_alu.upd_ov ? i_alu.ovf :
    i_sr_wr ? i_wdata[ST_SOVF] : signed_overflow_flag_q;
  assign half_carry_flag_d = i_alu.upd_dc ? alu_dc :
    i_sr_wr ? i_wdata[ST_HALF] : half_carry_flag_q;

  // -------------------------------------------------------------------------
  // Interrupt priority level
  // -------------------------------------------------------------------------
  wire logic low_writable = i_sr_wr & ~i_nest_disable;

  assign priority_low_bits_d =
    i_ipl_load   ? i_ipl_value[2:0] :
    low_writable ? i_wdata[ST_PRIH:ST_PRIL] : priority_low_bits_q;

  // Interrupt logic may raise the top bit; software may only clear it
  assign priority_top_bit_d =
    i_ipl_load ? i_ipl_value[3] :
    (priority_top_bit_q & ~(i_cc_wr & ~i_wdata[CC_PRITOP]));

  assign o_cpu_ipl = {priority_top_bit_q, priority_low_bits_q};
  assign o_user_irq_disable = priority_top_bit_q |
    (priority_low_bits_q == IPL_LOCK);

  // -------------------------------------------------------------------------
  // Stack frame: set and cleared by the core only
  // -------------------------------------------------------------------------
  assign stack_frame_active_d = i_frame_set |
    (stack_frame_active_q & ~i_frame_clr);
  assign o_stack_frame_flat = stack_frame_active_q;

  // -------------------------------------------------------------------------
  // Status and control flops
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_a_overflow_q       <= ST_RESET[ST_AOVF];
      acc_b_overflow_q       <= ST_RESET[ST_BOVF];
      acc_a_sticky_sat_q     <= ST_RESET[ST_ASAT];
      acc_b_sticky_sat_q     <= ST_RESET[ST_BSAT];
      do_loop_active_q       <= ST_RESET[ST_DO];
      repeat_loop_active_q   <= ST_RESET[ST_REP];
      half_carry_flag_q      <= ST_RESET[ST_HALF];
      priority_low_bits_q    <= ST_RESET[ST_PRIH:ST_PRIL];
      negative_q             <= ST_RESET[ST_NEG];
      signed_overflow_flag_q <= ST_RESET[ST_SOVF];
      zero_q                 <= ST_RESET[ST_ZERO];
      carry_q                <= ST_RESET[ST_CARRY];
    end else begin
      acc_a_overflow_q       <= i_acc_a_ovf;
      acc_b_overflow_q       <= i_acc_b_ovf;
      acc_a_sticky_sat_q     <= acc_a_sticky_sat_d;
      acc_b_sticky_sat_q     <= acc_b_sticky_sat_d;
      do_loop_active_q       <= i_do_active;
      repeat_loop_active_q   <= i_repeat_active;
      half_carry_flag_q      <= half_carry_flag_d;
      priority_low_bits_q    <= priority_low_bits_d;
      negative_q             <= negative_d;
      signed_overflow_flag_q <= signed_overflow_flag_d;
      zero_q                 <= zero_d;
      carry_q                <= carry_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      var_q                   <= CC_RESET[CC_VAR];
      multiply_sign_select_q  <= CC_RESET[CC_USH:CC_USL];
      loop_nest_depth_q       <= CC_RESET[CC_DLH:CC_DLL];
      early_loop_terminate_q  <= CC_RESET[CC_ETERM];
      acc_a_sat_enable_q      <= CC_RESET[CC_ASATEN];
      acc_b_sat_enable_q      <= CC_RESET[CC_BSATEN];
      data_write_sat_enable_q <= CC_RESET[CC_DWSATEN];
      sat_mode_select_q       <= CC_RESET[CC_SATMODE];
      priority_top_bit_q      <= CC_RESET[CC_PRITOP];
      stack_frame_active_q    <= CC_RESET[CC_FRAME];
      rounding_select_q       <= CC_RESET[CC_ROUND];
      int_mode_q              <= CC_RESET[CC_IF];
    end else begin
      loop_nest_depth_q      <= i_do_depth;
      early_loop_terminate_q <= i_cc_wr & i_wdata[CC_ETERM];
      priority_top_bit_q     <= priority_top_bit_d;
      stack_frame_active_q   <= stack_frame_active_d;
      if (i_cc_wr) begin
        var_q                   <= i_wdata[CC_VAR];
        multiply_sign_select_q  <= i_wdata[CC_USH:CC_USL];
        acc_a_sat_enable_q      <= i_wdata[CC_ASATEN];
        acc_b_sat_enable_q      <= i_wdata[CC_BSATEN];
        data_write_sat_enable_q <= i_wdata[CC_DWSATEN];
        sat_mode_select_q       <= i_wdata[CC_SATMODE];
        rounding_select_q       <= i_wdata[CC_ROUND];
        int_mode_q              <= i_wdata[CC_IF];
      end
    end
  end

  // One-cycle pulse; the core ends the loop at the close of this iteration
  assign o_early_terminate = early_loop_terminate_q;
  assign o_var_exception   = var_q;

  // -------------------------------------------------------------------------
  // DSP settings
  // -------------------------------------------------------------------------
  assign o_dsp_cfg.mul_type = csc_mul_e'(multiply_sign_select_q);
  assign o_dsp_cfg.mul_integer           = int_mode_q;
  assign o_dsp_cfg.round_biased          = rounding_select_q;
  assign o_dsp_cfg.acc_a_sat_enable      = acc_a_sat_enable_q;
  assign o_dsp_cfg.acc_b_sat_enable      = acc_b_sat_enable_q;
  assign o_dsp_cfg.data_write_sat_enable = data_write_sat_enable_q;
  assign o_dsp_cfg.super_sat             = sat_mode_select_q;

  // -------------------------------------------------------------------------
  // Read views
  // -------------------------------------------------------------------------
  assign o_sr_rdata = {acc_a_overflow_q, acc_b_overflow_q,
                       acc_a_sticky_sat_q, acc_b_sticky_sat_q,
                       combined_overflow, combined_sticky_sat,
                       do_loop_active_q, half_carry_flag_q,
                       priority_low_bits_q, repeat_loop_active_q,
                       negative_q, signed_overflow_flag_q,
                       zero_q, carry_q};

  // Early-terminate bit always reads zero; bit 14 unimplemented
  assign o_cc_rdata = {var_q, 1'b0, multiply_sign_select_q, 1'b0,
                       loop_nest_depth_q,
                       acc_a_sat_enable_q, acc_b_sat_enable_q,
                       data_write_sat_enable_q, sat_mode_select_q,
                       priority_top_bit_q, stack_frame_active_q,
                       rounding_select_q, int_mode_q};

endmodule : csc_regs

`default_nettype wire

//--- csc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module csc_regs_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_sr_wr,
  input wire logic        i_cc_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_sr_rdata,
  input wire logic [15:0] o_cc_rdata,
  input wire logic        i_acc_a_ovf,
  input wire logic        i_acc_a_sat,
  input wire logic        i_ipl_load,
  input wire logic        i_nest_disable,
  input wire logic [3:0]  o_cpu_ipl,
  input wire logic        o_user_irq_disable,
  input wire logic        o_early_terminate
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_comb_ovf: assert property (
    o_sr_rdata[11] == (o_sr_rdata[15] | o_sr_rdata[14]))
    else $error("combined overflow wrong");
  a_comb_sticky: assert property (
    o_sr_rdata[10] == (o_sr_rdata[13] | o_sr_rdata[12]))
    else $error("combined sticky wrong");
  a_ovf_mirror: assert property (
    1'b1 |=> o_sr_rdata[15] == $past(i_acc_a_ovf))
    else $error("overflow A not mirrored");
  a_sticky_set: assert property (i_acc_a_sat |=> o_sr_rdata[13])
    else $error("sticky A not set");
  a_early_pulse: assert property (
    i_cc_wr && i_wdata[11] |=> o_early_terminate && !o_cc_rdata[11]
    ##1 !o_early_terminate) else $error("early terminate pulse wrong");
  a_ipl_concat: assert property (
    o_cpu_ipl == {o_cc_rdata[3], o_sr_rdata[7:5]})
    else $error("priority level wrong");
  a_irq_off: assert property (
    o_user_irq_disable == (o_cc_rdata[3] || o_sr_rdata[7:5] == 3'h7))
    else $error("user interrupt disable wrong");
  a_ipl_locked: assert property (
    i_sr_wr && i_nest_disable && !i_ipl_load |=> $stable(o_sr_rdata[7:5]))
    else $error("locked priority bits changed");
  a_top_noset: assert property (
    !o_cc_rdata[3] && !i_ipl_load |=> !o_cc_rdata[3])
    else $error("top priority set by software");
endmodule : csc_regs_sva

bind csc_regs csc_regs_sva u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sr_wr(i_sr_wr), .i_cc_wr(i_cc_wr),
  .i_wdata(i_wdata), .o_sr_rdata(o_sr_rdata), .o_cc_rdata(o_cc_rdata),
  .i_acc_a_ovf(i_acc_a_ovf), .i_acc_a_sat(i_acc_a_sat),
  .i_ipl_load(i_ipl_load), .i_nest_disable(i_nest_disable),
  .o_cpu_ipl(o_cpu_ipl), .o_user_irq_disable(o_user_irq_disable),
  .o_early_terminate(o_early_terminate));
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csc_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, i_sr_wr = 0, i_cc_wr = 0;
  logic [15:0] i_wdata = '0, sr, cc;
  logic [1:0]  ovf, sat;
  logic [2:0]  depth;
  logic [3:0]  ipl, cpu_ipl;
  logic        do_on, rep_on, fset, fclr, iload, nest;
  logic        irq_off, early, flat, varx;
  csc_alu_s    alu;
  csc_dsp_s    dsp;
  int          n_mismatch = 0, checked = 0;

  always #25 i_clk = ~i_clk;

  csc_core_model u_core (.i_clk(i_clk), .o_alu(alu), .o_ovf(ovf),
    .o_sat(sat), .o_do(do_on), .o_rep(rep_on), .o_depth(depth),
    .o_fset(fset), .o_fclr(fclr), .o_iload(iload), .o_ipl(ipl),
    .o_nest(nest));
  csc_regs u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sr_wr(i_sr_wr),
    .i_cc_wr(i_cc_wr), .i_wdata(i_wdata), .o_sr_rdata(sr),
    .o_cc_rdata(cc), .i_alu(alu), .i_acc_a_ovf(ovf[1]),
    .i_acc_b_ovf(ovf[0]), .i_acc_a_sat(sat[1]), .i_acc_b_sat(sat[0]),
    .i_do_active(do_on), .i_repeat_active(rep_on), .i_do_depth(depth),
    .i_frame_set(fset), .i_frame_clr(fclr), .i_ipl_load(iload),
    .i_ipl_value(ipl), .i_nest_disable(nest), .o_cpu_ipl(cpu_ipl),
    .o_user_irq_disable(irq_off), .o_early_terminate(early),
    .o_stack_frame_flat(flat), .o_var_exception(varx), .o_dsp_cfg(dsp));

  task automatic cmp(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  // Strobe stays up exactly one edge; read views are settled on return
  task automatic wr(input logic s, input logic [15:0] d);
    step(1);
    {i_sr_wr, i_cc_wr, i_wdata} = {s, !s, d};
    step(1);
    {i_sr_wr, i_cc_wr} = 2'b00;
  endtask : wr

  task automatic close_out;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_dsp;
    logic [15:0] w;
    u_core.lvl(2'b00, 0, 0, 3'h5, 0);
    for (int i = 0; i < 4; i++) begin
      w = {2'b11, 2'(i), 4'hF, 2'(i), ~2'(i), 2'b11, 2'(i)};
      wr(0, w);
      cmp(16'(early), 16'h0001);
      cmp(cc, (w & 16'hB0F3) | 16'h0500);
      cmp(16'(dsp), {8'h00, w[13:12], w[0], w[1], w[7:4]});
      cmp(16'(varx), 16'h0001);
      step(1);
      cmp(16'(early), 16'h0000);
    end
  endtask : t_dsp

  task automatic t_acc;
    u_core.lvl(2'b10, 0, 0, 3'h0, 0);
    cmp(sr & 16'hFC00, 16'h8800);
    u_core.lvl(2'b01, 0, 0, 3'h0, 0);
    cmp(sr & 16'hFC00, 16'h4800);
    u_core.lvl(2'b00, 0, 0, 3'h0, 0);
    u_core.pulse(2'b10, 2'b00, 5'h00);
    step(3);
    cmp(sr & 16'hFC00, 16'h2400);
    wr(1, 16'h3000);
    cmp(sr & 16'h3400, 16'h0000);
    u_core.pulse(2'b11, 2'b00, 5'h00);
    cmp(sr & 16'h3400, 16'h3400);
    wr(1, 16'h2400);
    cmp(sr & 16'h3400, 16'h2400);
    wr(1, 16'h1400);
    cmp(sr & 16'h3400, 16'h0000);
  endtask : t_acc

  task automatic t_alu;
    u_core.alu('{upd_c:1, upd_z:1, upd_n:1, upd_ov:1, upd_dc:1, byte_op:1,
                 carry_b4:1, neg:1, ovf:1, carry_msb:1, default:0});
    cmp(sr & 16'h010F, 16'h010D);
    u_core.alu('{upd_dc:1, carry_b4:1, default:0});
    cmp(sr & 16'h0100, 16'h0000);
    u_core.alu('{upd_z:1, zero:1, default:0});
    cmp(sr & 16'h0002, 16'h0002);
    u_core.alu('{upd_z:1, zero:1, z_keep:1, default:0});
    cmp(sr & 16'h0002, 16'h0002);
    u_core.alu('{upd_z:1, upd_c:1, default:0});
    cmp(sr & 16'h000F, 16'h000C);
    u_core.alu('{upd_c:1, subtract:1, carry_msb:1, default:0});
    cmp(sr & 16'h000F, 16'h000D);
  endtask : t_alu

  task automatic t_ipl;
    for (int l = 0; l < 8; l++) begin
      wr(1, 16'(l) << 5);
      cmp(16'(cpu_ipl), 16'(l));
      cmp(16'(irq_off), 16'(l == 7));
    end
    u_core.lvl(2'b00, 0, 0, 3'h0, 1);
    wr(1, 16'h0040);
    cmp(16'(cpu_ipl), 16'h0007);
    u_core.lvl(2'b00, 0, 0, 3'h0, 0);
    u_core.pulse(2'b00, 2'b00, 5'h1A);
    cmp({11'h0, irq_off, cpu_ipl}, 16'h001A);
    for (int k = 0; k < 2; k++) begin
      wr(0, 16'h0020 | 16'(k << 3));
      cmp({11'h0, irq_off, cpu_ipl}, 16'h0002);
    end
  endtask : t_ipl

  task automatic t_frame;
    u_core.pulse(2'b00, 2'b10, 5'h00);
    wr(0, 16'h0020);
    cmp(16'({flat, cc[2]}), 16'h0003);
    u_core.pulse(2'b00, 2'b11, 5'h00);
    cmp(16'({flat, cc[2]}), 16'h0003);
    u_core.pulse(2'b00, 2'b01, 5'h00);
    cmp(16'({flat, cc[2]}), 16'h0000);
    u_core.lvl(2'b00, 1, 1, 3'h0, 0);
    cmp(sr & 16'h0210, 16'h0210);
    u_core.lvl(2'b00, 0, 1, 3'h0, 0);
    cmp(sr & 16'h0210, 16'h0010);
  endtask : t_frame

  initial begin
    step(19);
    cmp(sr, ST_RESET);
    cmp(cc, CC_RESET);
    cmp(16'(dsp), 16'h0002);
    step(1);
    i_rst_n = 1;
    t_dsp();
    t_acc();
    t_alu();
    t_ipl();
    t_frame();
    close_out();
  end

  // Whole run needs well under 400 cycles
  initial begin
    #(50 * 4000);
    n_mismatch++;
    close_out();
  end
endmodule : tb
`default_nettype wire
